// File: src/sdor_ctrl.sv
`timescale 1ns/1ps
// How it works
// - codes +8 and -8 are full scale
// - overload when over five of eight full scale
// - overload resets loop, adds 6 dB attenuation
// - loop reset released after 16 cycles
// - attenuation returns over following 48 cycles
// - new overload restarts whole sequence
// - output valid again 64 cycles after last overload, when recovery ends
module sdor_ctrl
  import sdor_pkg::*;
#(
  parameter int WIN_N   = WIN_LEN,
  parameter int WIN_MAX = WIN_LIMIT
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // quantizer side
  input  wire logic [CODE_W-1:0] quant_code,
  // attenuator base setting, same clock domain
  input  wire logic [ATT_W-1:0]  att_base,
  // modulator control
  output logic                   loop_reset,
  output logic [ATT_W-1:0]       att_out,
  // status
  output logic                   overload,
  output logic                   out_valid
);
  initial
  begin
    if (WIN_MAX >= WIN_N) $error("limit must be below window");
  end

  localparam int HW = $clog2(WIN_N+1);

  // ==========================================================
  // detection
  logic [CODE_W-1:0] code_reg;
  logic              hit;
  logic [HW-1:0]     hits;
  logic              ovl_now;

  // sample input code each cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      code_reg <= '0;
    else
      code_reg <= quant_code;
  end

  // full-scale decode
  always_comb
  begin
    hit = (code_reg == CODE_POS_FS)
          || (code_reg == CODE_NEG_FS);
  end

  sdor_window #(
    .N      (WIN_N)
  ) u_win (
    .clk    (clk),
    .rst    (rst),
    .fs_hit (hit),
    .hits   (hits)
  );

  // threshold compare
  always_comb
  begin
    ovl_now = (hits > HW'(WIN_MAX));
  end

  // ==========================================================
  // recovery sequence
  sdor_state_e       state_reg;
  sdor_state_e       state_next;
  logic [6:0]        cnt_reg;
  logic [6:0]        cnt_next;
  logic [ATT_W-1:0]  extra_reg;
  logic [ATT_W-1:0]  extra_next;
  logic [6:0]        quiet_reg;
  logic [6:0]        quiet_next;
  logic              lr_next;
  logic [ATT_W-1:0]  att_next;
  logic              val_next;

  // next-state and output computation
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    extra_next = extra_reg;
    if (ovl_now)
    begin
      state_next = SDOR_RESET;
      cnt_next   = 7'(RST_CYCLES - 1);
      extra_next = ATT_BOOST_DB;
    end
    else
    begin
      case (state_reg)
        SDOR_IDLE:
          cnt_next = '0;
        SDOR_RESET:
        begin
          if (cnt_reg == '0)
          begin
            state_next = SDOR_RAMP;
            cnt_next   = 7'(RAMP_CYCLES - 1);
          end
          else
            cnt_next = cnt_reg - 7'h01;
        end
        SDOR_RAMP:
        begin
          // one dB step every 8 cycles, 6 steps over 48 cycles
          if (cnt_reg[2:0] == 3'h0 && extra_reg != '0)
            extra_next = extra_reg - 5'h01;
          if (cnt_reg == '0)
          begin
            state_next = SDOR_IDLE;
            extra_next = '0;
          end
          else
            cnt_next = cnt_reg - 7'h01;
        end
        default:
        begin
          state_next = SDOR_IDLE;
          cnt_next   = '0;
          extra_next = '0;
        end
      endcase
    end
    lr_next  = (state_next == SDOR_RESET);
    att_next = att_base + extra_next;
    // cycles since last overload detected
    if (ovl_now)
      quiet_next = '0;
    else if (quiet_reg != 7'(VALID_CYCLES))
      quiet_next = quiet_reg + 7'h01;
    else
      quiet_next = quiet_reg;
    val_next = (quiet_next == 7'(VALID_CYCLES));
  end

  // register sequence state and outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg  <= SDOR_IDLE;
      cnt_reg    <= '0;
      extra_reg  <= ATT_RST;
      quiet_reg  <= 7'(VALID_CYCLES);
      loop_reset <= 1'b0;
      att_out    <= ATT_RST;
      overload   <= 1'b0;
      out_valid  <= 1'b1;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      extra_reg  <= extra_next;
      quiet_reg  <= quiet_next;
      loop_reset <= lr_next;
      att_out    <= att_next;
      overload   <= ovl_now;
      out_valid  <= val_next;
    end
  end

  // ==========================================================
  // checks
  logic [6:0]        age_reg;
  logic [6:0]        age_next;
  logic              settle_reg;
  logic [ATT_W-1:0]  ext_exp;

  // cycles since overload was last shown, saturating
  always_comb
  begin
    if (overload)
      age_next = '0;
    else if (age_reg != 7'h7F)
      age_next = age_reg + 7'h01;
    else
      age_next = age_reg;
    // extra attenuation expected at this age, 8 cycles a step
    if (age_reg < 7'(RST_CYCLES + 7))
      ext_exp = ATT_BOOST_DB;
    else if (age_reg < 7'(RST_CYCLES + RAMP_CYCLES - 1))
      ext_exp = ATT_BOOST_DB - 5'((age_reg - 7'(RST_CYCLES - 1)) >> 3);
    else
      ext_exp = '0;
  end

  // register helpers; settle masks the first cycle after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      age_reg    <= 7'h7F;
      settle_reg <= 1'b1;
    end
    else
    begin
      age_reg    <= age_next;
      settle_reg <= 1'b0;
    end
  end

  a_reset_on_ovl:
    assert property (@(posedge clk) disable iff (rst)
      overload |-> loop_reset
        && att_out == 5'($past(att_base) + ATT_BOOST_DB))
    else $error("overload did not reset loop and boost attenuation");

  a_reset_length:
    assert property (@(posedge clk) disable iff (rst)
      !overload |-> loop_reset == (age_reg < 7'(RST_CYCLES - 1)))
    else $error("loop reset length wrong");

  a_reset_release:
    assert property (@(posedge clk) disable iff (rst)
      !overload && age_reg == 7'(RST_CYCLES - 2) |->
        loop_reset ##1 (!loop_reset || overload))
    else $error("loop reset not released after 16 cycles");

  a_ramp_done:
    assert property (@(posedge clk) disable iff (rst)
      !settle_reg && !overload
        && age_reg >= 7'(RST_CYCLES + RAMP_CYCLES - 1) |->
        state_reg == SDOR_IDLE && att_out == $past(att_base))
    else $error("attenuation ramp length wrong");

  a_att_profile:
    assert property (@(posedge clk) disable iff (rst)
      !settle_reg && !overload |->
        att_out == 5'($past(att_base) + ext_exp))
    else $error("attenuation step out of place");

  a_att_ceiling:
    assert property (@(posedge clk) disable iff (rst)
      !loop_reset && !overload |->
        att_out <= 5'($past(att_base) + ATT_BOOST_DB))
    else $error("attenuation above boost during ramp");

  a_restart_seq:
    assert property (@(posedge clk) disable iff (rst)
      state_reg == SDOR_RAMP && ovl_now |=> state_reg == SDOR_RESET
        && cnt_reg == 7'(RST_CYCLES - 1))
    else $error("overload did not restart sequence");

  a_detect_count:
    assert property (@(posedge clk) disable iff (rst)
      (hits > HW'(WIN_MAX)) |=> overload)
    else $error("overload not flagged");

  a_valid_back:
    assert property (@(posedge clk) disable iff (rst)
      $fell(overload) |-> !out_valid [*8])
    else $error("valid returned too soon");

  a_valid_timing:
    assert property (@(posedge clk) disable iff (rst)
      out_valid == (!overload && age_reg >= 7'(VALID_CYCLES - 1)))
    else $error("valid not back 64 cycles after overload");
endmodule

// File: src/sdor_pkg.sv
package sdor_pkg;
  // ==========================================================
  // quantizer code format
  localparam int          CODE_W       = 5;
  localparam logic [4:0]  CODE_POS_FS  = 5'h08;  // +8
  localparam logic [4:0]  CODE_NEG_FS  = 5'h18;  // -8, two's complement
  // ==========================================================
  // detection window
  localparam int          WIN_LEN      = 8;
  localparam int          WIN_LIMIT    = 5;      // overload above this
  // ==========================================================
  // recovery timing, in modulator clock cycles
  localparam int          RST_CYCLES   = 16;
  localparam int          RAMP_CYCLES  = 48;
  localparam int          VALID_CYCLES = 64;
  // ==========================================================
  // attenuation, in 1 dB steps
  localparam int          ATT_W        = 5;
  localparam logic [4:0]  ATT_BOOST_DB = 5'h06;
  localparam logic [4:0]  ATT_RST      = 5'h00;
  // ==========================================================
  // recovery states
  typedef enum logic [1:0] {
    SDOR_IDLE,
    SDOR_RESET,
    SDOR_RAMP
  } sdor_state_e;
endpackage

// File: src/sdor_window.sv
`timescale 1ns/1ps
// ==========================================================
// sliding count of full-scale samples over the last N
module sdor_window
  import sdor_pkg::*;
#(
  parameter int N = WIN_LEN
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // one full-scale flag per cycle
  input  wire logic         fs_hit,
  // number of hits in window
  output logic [$clog2(N+1)-1:0] hits
);
  initial
  begin
    if (N < 2) $error("window too short");
  end

  logic [N-1:0]            hist_reg;
  logic [N-1:0]            hist_next;
  logic [$clog2(N+1)-1:0]  cnt_reg;
  logic [$clog2(N+1)-1:0]  cnt_next;

  // shift in newest, drop oldest, keep count
  always_comb
  begin
    hist_next = {hist_reg[N-2:0], fs_hit};
    cnt_next  = cnt_reg + {{($clog2(N+1)-1){1'b0}}, fs_hit}
                - {{($clog2(N+1)-1){1'b0}}, hist_reg[N-1]};
  end

  // register window
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hist_reg <= '0;
      cnt_reg  <= '0;
    end
    else
    begin
      hist_reg <= hist_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign hits = cnt_reg;
endmodule

// File: testbench/sdor_quant_model.sv
`timescale 1ns/1ps
// ==========================================================
// quantizer stand-in, one code per modulator clock
module sdor_quant_model
  import sdor_pkg::*;
(
  // clock
  input  wire logic              clk,
  // 0 in range, 1 +fs, 2 -fs, 3 five of every eight full scale
  input  wire logic [1:0]        mode,
  // quantizer code
  output logic [CODE_W-1:0]      code
);
  int unsigned       ph = 0;
  logic [CODE_W-1:0] mid;

  initial code = 5'h00;

  // new code after each rising edge
  always @(posedge clk)
  begin
    ph <= ph + 1;
    mid = 5'($urandom_range(14)) - 5'h07;  // -7..+7
    case (mode)
      2'h0:    code <= mid;
      2'h1:    code <= CODE_POS_FS;
      2'h2:    code <= CODE_NEG_FS;
      default: code <= (ph % 8 < 5) ? (ph[0] ? CODE_POS_FS : CODE_NEG_FS)
                                     : mid;
    endcase
  end
endmodule

// File: testbench/sdor_ctrl_tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the overload recovery controller
module sdor_ctrl_tb
  import sdor_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [4:0]  att_base = 5'h00;
  logic [4:0]  quant_code;
  logic [4:0]  att_out;
  logic        loop_reset;
  logic        overload;
  logic        out_valid;
  int          bad_count = 0;
  int          n_compared = 0;
  // reference model state
  int          win[$];
  logic [4:0]  creg = 5'h00;
  int          n;
  int          st = 0;
  int          rc = 0;
  int          ex = 0;
  int          qc = 63;
  logic        m_lr = 1'b0;
  logic        m_ovl = 1'b0;
  logic        m_val = 1'b1;
  logic [4:0]  m_att = 5'h00;

  initial
  begin
    forever #2 clk = ~clk;
  end

  sdor_quant_model u_src (.clk(clk), .mode(mode), .code(quant_code));

  sdor_ctrl u_dut (
    .clk        (clk),
    .rst        (rst),
    .quant_code (quant_code),
    .att_base   (att_base),
    .loop_reset (loop_reset),
    .att_out    (att_out),
    .overload   (overload),
    .out_valid  (out_valid)
  );

  // ==========================================================
  // reference model, integers and a queue
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      win = {};
      creg = 5'h00;
      st = 0;
      ex = 0;
      qc = 63;
      {m_lr, m_ovl, m_val, m_att} = {3'b001, 5'h00};
    end
    else
    begin
      n = 0;
      foreach (win[i]) n += win[i];
      m_ovl = (n > WIN_LIMIT);
      win.push_back(int'(creg == CODE_POS_FS || creg == CODE_NEG_FS));
      if (win.size() > WIN_LEN) void'(win.pop_front());
      creg = quant_code;
      if (m_ovl)
      begin
        st = 1;
        rc = RST_CYCLES - 1;
        ex = 6;
        qc = 0;
        m_val = 1'b0;
      end
      else
      begin
        if (st == 1)
        begin
          if (rc == 0) {st, rc} = {32'd2, 32'(RAMP_CYCLES - 1)};
          else rc--;
        end
        else if (st == 2)
        begin
          if (rc % 8 == 0) ex--;
          if (rc == 0) st = 0;
          else rc--;
        end
        if (qc == VALID_CYCLES - 1) m_val = 1'b1;
        else qc++;
      end
      m_lr = (st == 1);
      m_att = att_base + 5'(ex);
    end
  end

  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // compare every cycle where outputs are settled
  always @(negedge clk)
  begin
    chk(5'(overload), 5'(m_ovl));
    chk(5'(loop_reset), 5'(m_lr));
    chk(att_out, m_att);
    chk(5'(out_valid), 5'(m_val));
  end

  task automatic run(input logic [1:0] md, input int cyc);
    mode <= md;
    repeat (cyc) @(posedge clk);
  endtask

  task automatic done(input string s);
    att_base <= 5'($urandom_range(19));
    $display("test %s done, mismatches %0d", s, bad_count);
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial
  begin
    void'($urandom(32'h14A3891C));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    done("reset");
    run(2'h0, 40);
    done("in range");
    run(2'h3, 64);
    done("five of eight");
    run(2'h0, 10);
    run(2'h1, 6);
    run(2'h0, 120);
    done("single overload");
    run(2'h2, 30);
    run(2'h0, 40);
    run(2'h1, 8);
    run(2'h0, 120);
    done("restart");
    run(2'h2, 10);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    run(2'h0, 80);
    done("mid reset");
    give_verdict();
  end

  // watchdog
  initial
  begin
    #(5000 * 4);
    bad_count++;
    give_verdict();
  end
endmodule
